// ==== rtl/slm_line_ctrl.sv ====
`default_nettype none
module slm_line_ctrl
  import slm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  input  wire slm_proto_type proto,
  input  wire logic [2:0]    clock_mode,
  input  wire logic          high_speed,
  input  wire logic          bus_config,
  input  wire slm_line_type  line,
  input  wire logic          cts_n,
  input  wire logic          cd_pin,
  input  wire logic          rxd_pin,
  input  wire logic          tx_bit,
  output logic               rts_n,
  output logic               tx_enable,
  output logic               rx_enable,
  output logic               cd_strobe,
  output logic               rx_bit,
  output logic               txd_out,
  output slm_mode_type       mode
);
  // ============================================================
  // State.
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic        rts_n;
    logic        tx_run;
    logic        rx_en;
    logic        cd_strobe;
    logic        rx_bit;
    logic        txd;
  } slm_state_type;

  slm_state_type s_q;
  slm_state_type s_d;

  function automatic logic cd_active(input logic pin, input logic inv);
    cd_active = pin ^ inv;
  endfunction : cd_active

  logic       char_mode;
  logic       flow_rts;
  logic       sw_rts;
  logic [1:0] soc;

  // ============================================================
  // Next state.
  always_comb begin
    s_d       = s_q;
    char_mode = (proto != SLM_PROTO_HDLC) || (mode.submode == SLM_SUB_PPP_ASYNC);
    sw_rts    = s_q.cfg[SLM_B_RTS] & ~high_speed;
    flow_rts  = s_q.cfg[SLM_B_RTS_FLOW_CONTROL_ENABLE];
    soc       = {s_q.cfg[SLM_B_SOC1], s_q.cfg[SLM_B_SOC0]};

    if (reg_wr && reg_addr == SLM_ADDR_CFG) begin
      s_d.cfg = reg_wdata & SLM_CFG_MASK;
    end
    s_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        SLM_ADDR_CFG:  s_d.rdata = s_q.cfg;
        SLM_ADDR_STAT: s_d.rdata = {26'h0, s_q.txd, s_q.rx_bit, s_q.cd_strobe, s_q.rx_en, s_q.tx_run, s_q.rts_n};
        default:       s_d.rdata = 32'h0000_0000;
      endcase
    end

    // RTS output selection.
    if (proto == SLM_PROTO_HDLC) begin
      if (sw_rts) begin
        s_d.rts_n = 1'b0;
      end else if (bus_config) begin
        case (soc)
          2'b10:   s_d.rts_n = 1'b1;
          2'b11:   s_d.rts_n = ~line.rx_active;
          default: s_d.rts_n = ~line.tx_active;
        endcase
      end else begin
        s_d.rts_n = ~line.tx_active;
      end
    end else begin
      if (sw_rts) begin
        s_d.rts_n = flow_rts;
      end else if (flow_rts) begin
        if (line.rx_shadow_empty) begin
          s_d.rts_n = 1'b0;
        end else if (line.rx_at_threshold) begin
          s_d.rts_n = 1'b1;
        end
      end else begin
        s_d.rts_n = ~line.txfifo_has_data;
      end
    end

    // Transmit gating; character modes stop only at a byte boundary.
    if (s_q.cfg[SLM_B_CTS_GATING_DISABLE] || high_speed || !cts_n) begin
      s_d.tx_run = 1'b1;
    end else if (!char_mode || line.byte_boundary || !s_q.tx_run) begin
      s_d.tx_run = 1'b0;
    end

    // Carrier detect use.
    s_d.cd_strobe = 1'b0;
    if (s_q.cfg[SLM_B_CAS]) begin
      s_d.rx_en = cd_active(cd_pin, s_q.cfg[SLM_B_ICD]);
    end else begin
      s_d.rx_en = 1'b1;
      if (clock_mode == SLM_CLK_MODE1 || clock_mode == SLM_CLK_MODE4) begin
        s_d.cd_strobe = cd_active(cd_pin, s_q.cfg[SLM_B_ICD]);
      end
    end

    // Loopback just inside the pins.
    s_d.txd    = tx_bit;
    s_d.rx_bit = s_q.cfg[SLM_B_TLP] ? tx_bit : rxd_pin;
  end

  // ============================================================
  // Registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q       <= '0;
      s_q.cfg   <= SLM_CFG_RESET;
      s_q.rts_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  slm_mode_decode u_dec (
    .clk  (clk),
    .nrst (nrst),
    .cfg  (s_q.cfg),
    .mode (mode)
  );

  assign reg_rdata = s_q.rdata;
  assign rts_n     = s_q.rts_n;
  assign tx_enable = s_q.tx_run;
  assign rx_enable = s_q.rx_en;
  assign cd_strobe = s_q.cd_strobe;
  assign rx_bit    = s_q.rx_bit;
  assign txd_out   = s_q.txd;

  // ============================================================
  // Checks.
  property p_hdlc_sw_rts;
    @(posedge clk) disable iff (!nrst)
      (proto == SLM_PROTO_HDLC && s_q.cfg[SLM_B_RTS] && !high_speed) |=> !rts_n;
  endproperty
  a_hdlc_sw_rts: assert property (p_hdlc_sw_rts) else $error("rts not forced low");

  property p_hdlc_auto;
    @(posedge clk) disable iff (!nrst)
      (proto == SLM_PROTO_HDLC && !sw_rts && !bus_config) |=> rts_n == !$past(line.tx_active);
  endproperty
  a_hdlc_auto: assert property (p_hdlc_auto) else $error("rts not following transmit");

  property p_soc_idle;
    @(posedge clk) disable iff (!nrst)
      (proto == SLM_PROTO_HDLC && !sw_rts && bus_config && soc == 2'b10) |=> rts_n;
  endproperty
  a_soc_idle: assert property (p_soc_idle) else $error("rts not idle");

  property p_async_force;
    @(posedge clk) disable iff (!nrst)
      (proto != SLM_PROTO_HDLC && sw_rts) |=> rts_n == $past(flow_rts);
  endproperty
  a_async_force: assert property (p_async_force) else $error("forced rts wrong");

  property p_async_fifo;
    @(posedge clk) disable iff (!nrst)
      (proto != SLM_PROTO_HDLC && !sw_rts && !flow_rts && line.txfifo_has_data) |=> !rts_n;
  endproperty
  a_async_fifo: assert property (p_async_fifo) else $error("rts not low with tx data");

  property p_flow_empty;
    @(posedge clk) disable iff (!nrst)
      (proto != SLM_PROTO_HDLC && !sw_rts && flow_rts && line.rx_shadow_empty) |=> !rts_n;
  endproperty
  a_flow_empty: assert property (p_flow_empty) else $error("flow rts not low");

  property p_cts_halt;
    @(posedge clk) disable iff (!nrst)
      (cts_n && !s_q.cfg[SLM_B_CTS_GATING_DISABLE] && !high_speed && !char_mode) |=> !tx_enable;
  endproperty
  a_cts_halt: assert property (p_cts_halt) else $error("transmitter not halted");

  property p_cas_gate;
    @(posedge clk) disable iff (!nrst)
      s_q.cfg[SLM_B_CAS] |=> rx_enable == ($past(cd_pin) ^ $past(s_q.cfg[SLM_B_ICD]));
  endproperty
  a_cas_gate: assert property (p_cas_gate) else $error("receiver not gated by carrier");

  property p_loop;
    @(posedge clk) disable iff (!nrst)
      s_q.cfg[SLM_B_TLP] |=> rx_bit == $past(tx_bit) && txd_out == $past(tx_bit);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path wrong");
endmodule : slm_line_ctrl
`default_nettype wire

// ==== rtl/slm_pkg.sv ====
`default_nettype none
package slm_pkg;
  localparam logic [7:0]  SLM_ADDR_CFG   = 8'h0C;
  localparam logic [7:0]  SLM_ADDR_STAT  = 8'h10;
  localparam logic [31:0] SLM_CFG_RESET  = 32'h0000_0000;
  localparam int SLM_B_SOC1 = 29;
  localparam int SLM_B_SOC0 = 28;
  localparam int SLM_B_ICD  = 22;
  localparam int SLM_B_RTS  = 20;
  localparam int SLM_B_RTS_FLOW_CONTROL_ENABLE = 19;
  localparam int SLM_B_CTS_GATING_DISABLE = 18;
  localparam int SLM_B_CAS  = 17;
  localparam int SLM_B_MDS1 = 15;
  localparam int SLM_B_MDS0 = 14;
  localparam int SLM_B_ADM  = 13;
  localparam int SLM_B_NRM  = 12;
  localparam int SLM_B_PPP1 = 11;
  localparam int SLM_B_PPP0 = 10;
  localparam int SLM_B_SYNC_CHAR_LENGTH = 11;
  localparam int SLM_B_DUAL = 10;
  localparam int SLM_B_MCS  = 9;
  localparam int SLM_B_TLP  = 8;
  localparam logic [31:0] SLM_CFG_MASK = 32'h307E_FF00;
  localparam logic [2:0]  SLM_CLK_MODE1 = 3'h1;
  localparam logic [2:0]  SLM_CLK_MODE4 = 3'h4;
  localparam logic [2:0]  SLM_CLK_MODE5 = 3'h5;

  typedef enum logic [1:0] {SLM_PROTO_HDLC, SLM_PROTO_ASYNC, SLM_PROTO_BISYNC} slm_proto_type;
  typedef enum logic [2:0] {SLM_SUB_AUTO, SLM_SUB_NONAUTO, SLM_SUB_ADDR, SLM_SUB_TRANSP,
                            SLM_SUB_PPP_OCTET, SLM_SUB_PPP_ASYNC, SLM_SUB_PPP_BIT} slm_sub_type;

  typedef struct packed {
    slm_sub_type submode;
    logic        addr16;
    logic        addr_recog;
    logic        half_duplex;
    logic        modulo128;
    logic        sync_len8;
    logic        dual_sync;
    logic        sync_bits16;
  } slm_mode_type;

  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic txfifo_has_data;
    logic rx_shadow_empty;
    logic rx_at_threshold;
    logic byte_boundary;
  } slm_line_type;
endpackage : slm_pkg
`default_nettype wire

// ==== rtl/slm_mode_decode.sv ====
`default_nettype none
module slm_mode_decode
  import slm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [31:0]   cfg,
  output slm_mode_type       mode
);
  // ============================================================
  // Mode decode registered so every consumer sees one settled view.
  slm_mode_type s_q;
  slm_mode_type s_d;
  logic [1:0]   hdlc_submode_select;
  logic [1:0]   ppp;

  always_comb begin
    hdlc_submode_select = {cfg[SLM_B_MDS1], cfg[SLM_B_MDS0]};
    ppp = {cfg[SLM_B_PPP1], cfg[SLM_B_PPP0]};
    s_d = '0;
    case (ppp)
      2'b01: s_d.submode = SLM_SUB_PPP_OCTET;
      2'b10: s_d.submode = SLM_SUB_PPP_ASYNC;
      2'b11: s_d.submode = SLM_SUB_PPP_BIT;
      default: begin
        case (hdlc_submode_select)
          2'b00: s_d.submode = SLM_SUB_AUTO;
          2'b01: s_d.submode = SLM_SUB_NONAUTO;
          2'b10: s_d.submode = SLM_SUB_ADDR;
          default: s_d.submode = SLM_SUB_TRANSP;
        endcase
      end
    endcase
    s_d.addr16      = (s_d.submode == SLM_SUB_AUTO || s_d.submode == SLM_SUB_NONAUTO) && cfg[SLM_B_ADM];
    s_d.addr_recog  = (s_d.submode == SLM_SUB_ADDR) && cfg[SLM_B_ADM];
    s_d.half_duplex = (s_d.submode == SLM_SUB_AUTO) && cfg[SLM_B_NRM];
    s_d.modulo128   = (s_d.submode == SLM_SUB_AUTO) && cfg[SLM_B_MCS];
    s_d.sync_len8   = cfg[SLM_B_SYNC_CHAR_LENGTH];
    s_d.dual_sync   = cfg[SLM_B_DUAL];
    s_d.sync_bits16 = cfg[SLM_B_DUAL] & cfg[SLM_B_SYNC_CHAR_LENGTH];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mode = s_q;

  property p_modulo_auto_only;
    @(posedge clk) disable iff (!nrst)
      mode.modulo128 |-> mode.submode == SLM_SUB_AUTO;
  endproperty
  a_modulo_auto_only: assert property (p_modulo_auto_only) else $error("modulo 128 outside automode");

  property p_ppp_overrides;
    @(posedge clk) disable iff (!nrst)
      $past(cfg[SLM_B_PPP1] | cfg[SLM_B_PPP0]) |-> mode.submode inside {SLM_SUB_PPP_OCTET,
        SLM_SUB_PPP_ASYNC, SLM_SUB_PPP_BIT};
  endproperty
  a_ppp_overrides: assert property (p_ppp_overrides) else $error("submode not overridden by ppp");
endmodule : slm_mode_decode
`default_nettype wire

// ==== tb/slm_modem_model.sv ====
`default_nettype none
module slm_modem_model (
  input  wire logic clk,
  input  wire logic rts_n,
  input  wire logic hold,
  input  wire logic carrier,
  output logic      cts_n,
  output logic      cd_pin,
  output logic      rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Line side
  // The modem grants clear-to-send one cycle after request-to-send unless held off.
  // Received data toggles every cycle, so a stale or looped value cannot pass by luck.
  initial begin
    cts_n   = 1'b1;
    rxd_pin = 1'b0;
  end
  always @(posedge clk) begin
    cts_n   <= rts_n | hold;
    rxd_pin <= ~rxd_pin;
  end
  assign cd_pin = carrier;
endmodule : slm_modem_model
`default_nettype wire

// ==== tb/slm_testbench.sv ====
`default_nettype none
module testbench
  import slm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] K_RTS = 32'h0000_0001 << SLM_B_RTS;
  localparam logic [31:0] K_FRT = 32'h0000_0001 << SLM_B_RTS_FLOW_CONTROL_ENABLE;
  localparam logic [31:0] K_FCT = 32'h0000_0001 << SLM_B_CTS_GATING_DISABLE;
  localparam logic [31:0] K_CAS = 32'h0000_0001 << SLM_B_CAS;
  localparam logic [31:0] K_ICD = 32'h0000_0001 << SLM_B_ICD;
  localparam logic [31:0] K_TLP = 32'h0000_0001 << SLM_B_TLP;
  logic          clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic          high_speed = 1'b0, bus_config = 1'b0, tx_bit = 1'b0, hold = 1'b0, carrier = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [31:0]   reg_wdata = 32'h0000_0000, reg_rdata;
  logic [2:0]    clock_mode = 3'h0;
  slm_proto_type proto = SLM_PROTO_HDLC;
  slm_line_type  line_s = '0;
  slm_mode_type  mode;
  logic          cts_n, cd_pin, rxd_pin, rts_n, tx_enable, rx_enable, cd_strobe, rx_bit, txd_out;
  int            miscompares = 0, samples_checked = 0, cycles = 0;
  // ==========================================================================
  // Environment
  initial forever #2.5 clk = ~clk;
  slm_line_ctrl i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .proto(proto), .clock_mode(clock_mode),
    .high_speed(high_speed), .bus_config(bus_config), .line(line_s), .cts_n(cts_n), .cd_pin(cd_pin),
    .rxd_pin(rxd_pin), .tx_bit(tx_bit), .rts_n(rts_n), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .cd_strobe(cd_strobe), .rx_bit(rx_bit), .txd_out(txd_out), .mode(mode));
  slm_modem_model i_modem (.clk(clk), .rts_n(rts_n), .hold(hold), .carrier(carrier),
    .cts_n(cts_n), .cd_pin(cd_pin), .rxd_pin(rxd_pin));
  // ==========================================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic cfg(logic [31:0] d);
    wr(SLM_ADDR_CFG, d);
    settle();
  endtask : cfg
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    chk("rts_n reset", 1, rts_n);
    rd(SLM_ADDR_CFG, SLM_CFG_RESET);
    wr(SLM_ADDR_CFG, 32'hFFFF_FFFF);
    wr(8'h20, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(SLM_ADDR_CFG, SLM_CFG_MASK);
    cfg(32'h0000_0000);
  endtask : t_regs
  task automatic t_hdlc_rts();
    @(posedge clk) line_s.tx_active <= 1'b1;
    settle();
    chk("rts_n hdlc tx", 0, rts_n);
    @(posedge clk) line_s.tx_active <= 1'b0;
    settle();
    chk("rts_n hdlc idle", 1, rts_n);
    cfg(K_RTS);
    chk("rts_n hdlc forced", 0, rts_n);
    @(posedge clk) bus_config <= 1'b1;
    line_s.tx_active <= 1'b1;
    cfg(32'h2000_0000);
    chk("rts_n output ctl 10", 1, rts_n);
    @(posedge clk) line_s.tx_active <= 1'b0;
    line_s.rx_active <= 1'b1;
    cfg(32'h3000_0000);
    chk("rts_n output ctl 11", 0, rts_n);
    @(posedge clk) bus_config <= 1'b0;
    line_s.rx_active <= 1'b0;
  endtask : t_hdlc_rts
  task automatic t_async_rts();
    @(posedge clk) proto <= SLM_PROTO_ASYNC;
    line_s.txfifo_has_data <= 1'b1;
    cfg(32'h0000_0000);
    chk("rts_n fifo data", 0, rts_n);
    @(posedge clk) line_s.txfifo_has_data <= 1'b0;
    settle();
    chk("rts_n fifo empty", 1, rts_n);
    @(posedge clk) line_s.rx_shadow_empty <= 1'b1;
    cfg(K_FRT);
    chk("rts_n shadow empty", 0, rts_n);
    @(posedge clk) line_s.rx_shadow_empty <= 1'b0;
    line_s.rx_at_threshold <= 1'b1;
    settle();
    chk("rts_n threshold", 1, rts_n);
    cfg(K_RTS);
    chk("rts_n forced low", 0, rts_n);
    cfg(K_RTS | K_FRT);
    chk("rts_n forced high", 1, rts_n);
  endtask : t_async_rts
  task automatic t_cts();
    @(posedge clk) proto <= SLM_PROTO_HDLC;
    cfg(K_RTS);
    chk("tx_enable cts low", 1, tx_enable);
    @(posedge clk) hold <= 1'b1;
    settle();
    chk("tx_enable cts high", 0, tx_enable);
    cfg(K_RTS | K_FCT);
    chk("tx_enable gating off", 1, tx_enable);
    @(posedge clk) proto <= SLM_PROTO_ASYNC;
    hold <= 1'b0;
    cfg(K_RTS);
    @(posedge clk) hold <= 1'b1;
    settle();
    chk("tx_enable mid byte", 1, tx_enable);
    @(posedge clk) line_s.byte_boundary <= 1'b1;
    @(posedge clk) line_s.byte_boundary <= 1'b0;
    settle();
    chk("tx_enable byte end", 0, tx_enable);
    @(posedge clk) high_speed <= 1'b1;
    settle();
    chk("tx_enable high speed", 1, tx_enable);
    @(posedge clk) high_speed <= 1'b0;
    hold <= 1'b0;
  endtask : t_cts
  task automatic t_carrier();
    @(posedge clk) clock_mode <= SLM_CLK_MODE1;
    carrier <= 1'b1;
    cfg(32'h0000_0000);
    chk("cd_strobe mode 1", 1, cd_strobe);
    cfg(K_CAS);
    chk("rx_enable cd on", 1, rx_enable);
    @(posedge clk) carrier <= 1'b0;
    settle();
    chk("rx_enable cd off", 0, rx_enable);
    cfg(K_CAS | K_ICD);
    chk("rx_enable cd inverted", 1, rx_enable);
  endtask : t_carrier
  task automatic t_loop_mode();
    // high_speed is held low here, so the loop runs outside the high speed mode.
    cfg(K_TLP);
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk) tx_bit <= b[0];
      settle();
      chk("rx_bit loop", b, rx_bit);
      chk("txd_out loop", b, txd_out);
    end
    @(posedge clk) proto <= SLM_PROTO_HDLC;
    cfg(32'h0000_8000);
    chk("submode address", SLM_SUB_ADDR, mode.submode);
    // Async reception enable lives in the mode register outside this block.
    cfg(32'h0000_8800);
    chk("submode ppp async", SLM_SUB_PPP_ASYNC, mode.submode);
  endtask : t_loop_mode
  // ==========================================================================
  // Main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_regs();
    t_hdlc_rts();
    t_async_rts();
    t_cts();
    t_carrier();
    t_loop_mode();
    conclude();
  end
endmodule : testbench
`default_nettype wire
